// ---- hw/spe_map.svh ----
// Purpose: named constants for the serial memory front end
// Assumes: included by bare name from every design file that needs it
// Notes: opcodes are compared after masking bit 3
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH
// opcodes, bit 3 is don't care
`define SPE_OP_MASK 8'hF7
`define SPE_OP_SET_LATCH 8'h06
`define SPE_OP_CLR_LATCH 8'h04
`define SPE_OP_STAT_RD 8'h05
`define SPE_OP_STAT_WR 8'h01
`define SPE_OP_ARR_RD 8'h03
`define SPE_OP_ARR_WR 8'h02
// status register bit positions
`define SPE_ST_BUSY 0
`define SPE_ST_LATCH 1
`define SPE_ST_LVL_LO 2
`define SPE_ST_LVL_HI 3
`define SPE_ST_PIN_EN 7
`define SPE_ST_BUSY_VAL 8'hFF
// power-up value of the nonvolatile bits {pin_en, lvl_hi, lvl_lo}
`define SPE_NV_RESET 3'h0
// pin idle levels {cs_n, sck, si, hold_n, wp_n}
`define SPE_PIN_IDLE 5'h13
// page write wraps inside this many low address bits
`define SPE_PAGE_BITS 5
// self-timed write cycle
`define SPE_TWC_MS 5
`define SPE_CLK_KHZ 100000
// defaults: larger density variant, four-entry write buffer
`define SPE_ADDR_W_DEF 11
`define SPE_FIFO_DEPTH 4
`endif

// ---- hw/spe_pkg.sv ----
// Purpose: shared types of the serial memory front end
// Assumes: nothing beyond the map header
// Notes: state codes are one-hot
package spe_pkg;
  // command sequencer states
  typedef enum logic [7:0] {
    ST_CMD = 8'h01,
    ST_ADDR_HI = 8'h02,
    ST_ADDR_LO = 8'h04,
    ST_WDATA = 8'h08,
    ST_RDATA = 8'h10,
    ST_STAT = 8'h20,
    ST_SWDATA = 8'h40,
    ST_IGNORE = 8'h80
  } spe_state_type;
  // one buffered array write: address (widest variant) and data
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } spe_wr_type;
endpackage : spe_pkg

// ---- hw/spe_fifo.sv ----
// Purpose: small write buffer between serial receive and the array
// Assumes: one clock, synchronous active-low reset
// Notes: flush drops all entries; depth must be a power of two
module spe_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("spe_fifo: DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  // full when pointers differ only in the wrap bit
  assign o_in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
  assign o_out_valid = wr_ptr != rd_ptr;
  assign o_out_data = store[rd_ptr[PW-1:0]];
  // pointers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // storage needs no reset, it is never read while empty
  always_ff @(posedge i_sys_clk) begin
    if (push) store[wr_ptr[PW-1:0]] <= i_in_data;
  end
endmodule : spe_fifo

// ---- hw/spe_mem.sv ----
// Purpose: byte-wide array of the serial memory
// Assumes: one write port and one registered read port
// Notes: contents are undefined after power-up
module spe_mem #(
  parameter int unsigned AW = 11
) (
  // clock
  input wire logic i_sys_clk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read port
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] cells [2**AW];
  // read data one cycle after the address
  always_ff @(posedge i_sys_clk) begin
    if (i_we) cells[i_waddr] <= i_wdata;
    o_rdata <= cells[i_raddr];
  end
endmodule : spe_mem

// ---- hw/spe_front_end.sv ----
// Purpose: serial slave front end of a small byte-wide nonvolatile memory
// Assumes: serial mode 0, pins sampled by a system clock far above sck
// Notes: a page write keeps at most FIFO_DEPTH bytes, further bytes drop
`include "spe_map.svh"
module spe_front_end #(
  parameter int unsigned ADDR_W = `SPE_ADDR_W_DEF,
  parameter int unsigned FIFO_DEPTH = `SPE_FIFO_DEPTH,
  parameter int unsigned WC_CYCLES = `SPE_TWC_MS * `SPE_CLK_KHZ
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial bus pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // control pins
  input wire logic i_hold_n,
  input wire logic i_wp_n
);
  localparam int unsigned WCW = $clog2(WC_CYCLES + 1);
  localparam int unsigned PB = `SPE_PAGE_BITS;
  localparam int unsigned SW = $bits(spe_pkg::spe_wr_type);
  if (ADDR_W != 10 && ADDR_W != 11) begin : g_aw_chk
    $error("spe_front_end: ADDR_W must be 10 or 11");
  end
  if (WC_CYCLES <= FIFO_DEPTH) begin : g_wc_chk
    $error("spe_front_end: write cycle too short to drain the buffer");
  end

  // opcode match with bit 3 masked off
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] c);
    op_is = (b & `SPE_OP_MASK) == c;
  endfunction : op_is

  // block protection: level 1 top quarter, 2 top half, 3 all
  function automatic logic prot_hit(input logic [ADDR_W-1:0] a,
                                    input logic [1:0] l);
    prot_hit = (l[1] & l[0]) | (l[1] & a[ADDR_W-1]) |
               (l[0] & (&a[ADDR_W-1 -: 2]));
  endfunction : prot_hit

  // pin synchronisers, the first stage feeds only the second
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic sck_d;
  logic cs_d;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_m <= `SPE_PIN_IDLE;
      pin_s <= `SPE_PIN_IDLE;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      pin_m <= {i_cs_n, i_sck, i_si, i_hold_n, i_wp_n};
      pin_s <= pin_m;
      sck_d <= pin_s[3];
      cs_d <= pin_s[4];
    end
  end

  // edges of the synchronised pins
  wire cs_s = pin_s[4];
  wire sck_s = pin_s[3];
  wire si_s = pin_s[2];
  wire hold_s = pin_s[1];
  wire wp_s = pin_s[0];
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire cs_fall = ~cs_s & cs_d;
  wire cs_rise = cs_s & ~cs_d;

  // pause only changes while sck is low, so a toggling sck is harmless
  logic paused;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || cs_s) paused <= 1'b0;
    else if (!sck_s) paused <= ~hold_s;
  end
  wire active = ~cs_s & ~paused;

  // state and registers
  spe_pkg::spe_state_type state;
  spe_pkg::spe_state_type next_state;
  spe_pkg::spe_state_type cmd_state;
  logic [2:0] bit_cnt;
  logic [6:0] sh_in;
  logic op_wr;
  logic [7:0] addr_hi;
  logic [ADDR_W-1:0] addr;
  logic [2:0] out_cnt;
  logic [7:0] out_sh;
  logic wel;
  logic pin_en;
  logic [1:0] lvl;
  logic wc_busy;
  logic wc_array;
  logic [WCW-1:0] wc_cnt;
  logic sw_got;
  logic sw_abort;
  logic [7:0] sw_byte;
  logic [7:0] mem_rdata;
  logic [7:0] status_idle;
  spe_pkg::spe_wr_type fifo_in;
  spe_pkg::spe_wr_type fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;

  // receive strobes; no input is taken once a command is dead
  wire rx_en = active & (state != spe_pkg::ST_IGNORE) & sck_rise;
  wire byte_done = rx_en & (&bit_cnt);
  wire [7:0] rx_byte = {sh_in, si_s};
  wire in_cmd = byte_done & (state == spe_pkg::ST_CMD);

  // opcode decode
  wire is_set = op_is(rx_byte, `SPE_OP_SET_LATCH);
  wire is_clr = op_is(rx_byte, `SPE_OP_CLR_LATCH);
  wire is_srd = op_is(rx_byte, `SPE_OP_STAT_RD);
  wire is_swr = op_is(rx_byte, `SPE_OP_STAT_WR);
  wire is_ard = op_is(rx_byte, `SPE_OP_ARR_RD);
  wire is_awr = op_is(rx_byte, `SPE_OP_ARR_WR);
  wire op_valid = is_set | is_clr | is_srd | is_swr | is_ard | is_awr;
  wire cmd_exec = in_cmd & ~wc_busy;

  // where the opcode leads; writes without the latch die here
  assign cmd_state = (wc_busy & ~is_srd) ? spe_pkg::ST_IGNORE :
                     is_srd ? spe_pkg::ST_STAT :
                     (is_swr & wel) ? spe_pkg::ST_SWDATA :
                     is_ard ? spe_pkg::ST_ADDR_HI :
                     (is_awr & wel) ? spe_pkg::ST_ADDR_HI :
                     spe_pkg::ST_IGNORE;

  // sequencer transitions
  always_comb begin
    next_state = state;
    if (cs_fall) begin
      next_state = spe_pkg::ST_CMD;
    end else if (byte_done) begin
      unique case (state)
        spe_pkg::ST_CMD: next_state = cmd_state;
        spe_pkg::ST_ADDR_HI: next_state = spe_pkg::ST_ADDR_LO;
        spe_pkg::ST_ADDR_LO: begin
          next_state = op_wr ? spe_pkg::ST_WDATA : spe_pkg::ST_RDATA;
        end
        spe_pkg::ST_SWDATA: next_state = spe_pkg::ST_IGNORE;
        spe_pkg::ST_WDATA,
        spe_pkg::ST_RDATA,
        spe_pkg::ST_STAT,
        spe_pkg::ST_IGNORE: next_state = state;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) state <= spe_pkg::ST_CMD;
    else state <= next_state;
  end

  // serial receive shifter, msb first
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || cs_fall) begin
      bit_cnt <= '0;
      sh_in <= '0;
    end else if (rx_en) begin
      bit_cnt <= bit_cnt + 3'h1;
      sh_in <= rx_byte[6:0];
    end
  end

  // write buffer path, refused bytes still advance the page address
  wire wr_byte = byte_done & (state == spe_pkg::ST_WDATA);
  wire wr_prot = prot_hit(addr, lvl);
  wire rd_step = active & sck_fall & (state == spe_pkg::ST_RDATA) &
                 (&out_cnt);
  assign fifo_in.addr = 11'(addr);
  assign fifo_in.data = rx_byte;

  // address assembly, page wrap on writes, full wrap on reads
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      op_wr <= 1'b0;
      addr_hi <= '0;
      addr <= '0;
    end else begin
      if (in_cmd) op_wr <= is_awr;
      if (byte_done && state == spe_pkg::ST_ADDR_HI) addr_hi <= rx_byte;
      if (byte_done && state == spe_pkg::ST_ADDR_LO) begin
        addr <= ADDR_W'({addr_hi, rx_byte});
      end else if (wr_byte) begin
        addr <= {addr[ADDR_W-1:PB], PB'(addr[PB-1:0] + 1'b1)};
      end else if (rd_step) begin
        addr <= addr + 1'b1;
      end
    end
  end

  // status register view
  always_comb begin
    status_idle = '0;
    status_idle[`SPE_ST_PIN_EN] = pin_en;
    status_idle[`SPE_ST_LVL_HI] = lvl[1];
    status_idle[`SPE_ST_LVL_LO] = lvl[0];
    status_idle[`SPE_ST_LATCH] = wel;
    status_idle[`SPE_ST_BUSY] = 1'b0;
  end
  wire [7:0] status_val = wc_busy ? `SPE_ST_BUSY_VAL : status_idle;

  // transmit: a fresh byte every eighth falling edge, status re-read
  wire tx_on = active & ((state == spe_pkg::ST_RDATA) |
                         (state == spe_pkg::ST_STAT));
  wire tx_step = tx_on & sck_fall;
  wire [7:0] tx_src = (state == spe_pkg::ST_RDATA) ? mem_rdata : status_val;
  wire [7:0] tx_byte = (out_cnt == 3'h0) ? tx_src : out_sh;
  assign o_so_oe = tx_on;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_so <= 1'b0;
      out_sh <= '0;
      out_cnt <= '0;
    end else if (cs_fall) begin
      out_cnt <= '0;
    end else if (tx_step) begin
      o_so <= tx_byte[~out_cnt];
      out_sh <= tx_byte;
      out_cnt <= out_cnt + 3'h1;
    end
  end

  // status write capture; with pin_en set, a protect pin low during the command kills it
  wire hw_prot = pin_en & ~wp_s;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || cs_fall) begin
      sw_got <= 1'b0;
      sw_abort <= 1'b0;
      sw_byte <= '0;
    end else begin
      if (byte_done && state == spe_pkg::ST_SWDATA) begin
        sw_got <= 1'b1;
        sw_byte <= rx_byte;
      end
      if (!cs_s && (sw_got || state == spe_pkg::ST_SWDATA) && hw_prot) begin
        sw_abort <= 1'b1;
      end
    end
  end

  // write cycle launch on select rising at a byte boundary
  wire at_bound = bit_cnt == 3'h0;
  wire sw_start = cs_rise & sw_got & at_bound & ~sw_abort & ~hw_prot &
                  wel & ~wc_busy;
  wire aw_start = cs_rise & (state == spe_pkg::ST_WDATA) & at_bound &
                  fifo_out_valid & ~wc_busy;
  wire wr_flush = cs_rise & (state == spe_pkg::ST_WDATA) & ~at_bound;
  wire wc_end = wc_busy & (wc_cnt == '0);

  // self-timed cycle; bits committed at launch so the pin cannot undo them
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wc_busy <= 1'b0;
      wc_array <= 1'b0;
      wc_cnt <= '0;
      {pin_en, lvl} <= `SPE_NV_RESET;
    end else if (sw_start || aw_start) begin
      wc_busy <= 1'b1;
      wc_array <= aw_start;
      wc_cnt <= WCW'(WC_CYCLES - 1);
      if (sw_start) begin
        pin_en <= sw_byte[`SPE_ST_PIN_EN];
        lvl <= sw_byte[`SPE_ST_LVL_HI:`SPE_ST_LVL_LO];
      end
    end else if (wc_end) begin
      wc_busy <= 1'b0;
    end else if (wc_busy) begin
      wc_cnt <= wc_cnt - 1'b1;
    end
  end

  // write latch: clear on power-up, on latch clear and on cycle end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) wel <= 1'b0;
    else if (wc_end) wel <= 1'b0;
    else if (cmd_exec && is_clr) wel <= 1'b0;
    else if (cmd_exec && is_set) wel <= 1'b1;
  end

  // write buffer, drained into the array only inside the write cycle
  spe_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_flush(wr_flush),
    .i_in_valid(wr_byte & ~wr_prot),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(wc_busy & wc_array),
    .o_out_data(fifo_out)
  );

  // array
  spe_mem #(
    .AW(ADDR_W)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(fifo_out_valid & wc_busy & wc_array),
    .i_waddr(fifo_out.addr[ADDR_W-1:0]),
    .i_wdata(fifo_out.data),
    .i_raddr(addr),
    .o_rdata(mem_rdata)
  );

  // checks
  so_off_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    cs_s |-> !o_so_oe) else $error("output driven while deselected");
  so_off_pause_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    paused |-> !o_so_oe) else $error("output driven in pause");
  pause_freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    paused && !cs_s && !cs_fall |=> $stable(bit_cnt))
    else $error("bit count moved in pause");
  bad_op_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    in_cmd && !op_valid && !cs_fall |=> state == spe_pkg::ST_IGNORE
      && !o_so_oe) else $error("bad opcode not ignored");
  busy_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    in_cmd && wc_busy && !is_srd |=> state == spe_pkg::ST_IGNORE)
    else $error("command obeyed while busy");
  busy_status_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wc_busy |-> status_val == `SPE_ST_BUSY_VAL)
    else $error("status not all ones while busy");
  latch_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(wc_busy) |-> !wel ##1 !wc_busy)
    else $error("latch survived write cycle");
  prot_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    sw_got && hw_prot && cs_rise |=> !wc_busy)
    else $error("protected status write ran");
  push_safe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_byte && wr_prot |=> $stable(fifo_out_valid) || wc_busy)
    else $error("protected byte buffered");
  cycle_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wc_busy && wc_cnt != '0 |=> wc_busy)
    else $error("write cycle ended early");
endmodule : spe_front_end

// ---- sim/spe_bus_master.sv ----
// Purpose: serial bus master model for the memory front end
// Assumes: mode 0, sck idles low and stands still between frames
// Notes: tasks are called by the bench through the instance name
module spe_bus_master (
  // pins toward the device
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_hold_n,
  // data back from the device
  input wire logic i_so,
  input wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  logic last_so = 1'b0;
  // idle pins at time zero
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // select falls with sck low so the first byte is the opcode
  task automatic open_frame;
    o_cs_n = 1'b0;
    #HALF;
  endtask : open_frame
  // msb first; a released so reads as the inverse of its last bit,
  // so a silent device never passes for a driven zero
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      #HALF;
      o_sck = 1'b1;
      last_so = i_so_oe ? i_so : ~last_so;
      rx[i] = last_so;
      #HALF;
      o_sck = 1'b0;
    end
  endtask : xfer
  // deselect inside the sck low time after the last bit
  task automatic close_frame;
    #HALF;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #(4 * HALF);
  endtask : close_frame
  // pause with sck low, then run sck and wiggle si to show both ignored
  task automatic pause_on(input int n);
    o_hold_n = 1'b0;
    #HALF;
    repeat (n) begin
      o_sck = 1'b1;
      o_si = ~o_si;
      #HALF;
      o_sck = 1'b0;
      #HALF;
    end
  endtask : pause_on
  // resume while sck is low
  task automatic pause_off;
    o_hold_n = 1'b1;
    #HALF;
  endtask : pause_off
endmodule : spe_bus_master

// ---- sim/tb_spe_front_end.sv ----
// Purpose: self-checking bench of the serial memory front end
// Assumes: large variant, write cycle shortened to WC clocks
// Notes: array contents are unknown at power-up, so each read follows a write
module tb_spe_front_end;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WC = 400;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wp_n = 1'b1;
  logic cs_n, sck, si, hold_n, so, so_oe;
  logic [7:0] rx;
  int fails = 0;
  int samples_checked = 0;
  // 100 MHz system clock
  always #5 i_sys_clk = ~i_sys_clk;
  spe_front_end #(.ADDR_W(11), .FIFO_DEPTH(4), .WC_CYCLES(WC)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_hold_n(hold_n),
    .i_wp_n(i_wp_n));
  spe_bus_master i_master (
    .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n),
    .i_so(so), .i_so_oe(so_oe));
  // compare tasks, one per result kind
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // one frame of n bytes taken from the low end of b, last byte kept in rx
  task automatic frame(input int n, input logic [31:0] b);
    i_master.open_frame();
    for (int k = n - 1; k >= 0; k--) i_master.xfer(b[8*k +: 8], rx);
    i_master.close_frame();
  endtask : frame
  task automatic rd_status(output logic [7:0] st);
    frame(2, 32'h0000_0500);
    st = rx;
  endtask : rd_status
  // poll busy; a cycle that never ends is a mismatch and ends the run
  task automatic wait_ready;
    logic [7:0] st;
    for (int t = 0; t < 20; t++) begin
      rd_status(st);
      if (st[0] === 1'b0) return;
    end
    fails++;
    stop_test();
  endtask : wait_ready
  task automatic set_wp(input logic v);
    @(negedge i_sys_clk);
    i_wp_n = v;
  endtask : set_wp
  task automatic t_reset;
    logic [7:0] st;
    check1(so_oe, 1'b0);
    rd_status(st);
    check8(st, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // both spellings of set and clear, clear with protect pin low
  task automatic t_latch;
    logic [7:0] st;
    logic [7:0] ops [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
    set_wp(1'b0);
    for (int k = 0; k < 2; k++) begin
      frame(1, {24'h00_0000, ops[2*k]});
      rd_status(st);
      check8(st, 8'h02);
      frame(1, {24'h00_0000, ops[2*k+1]});
      rd_status(st);
      check8(st, 8'h00);
    end
    set_wp(1'b1);
    $display("test latch done");
  endtask : t_latch
  // write at the level-one boundary, poll busy, set ignored while busy
  task automatic t_array;
    logic [7:0] st;
    frame(1, 32'h0000_0006);
    frame(4, 32'h0206_00A1);
    rd_status(st);
    check8(st, 8'hFF);
    frame(1, 32'h0000_0006);
    wait_ready();
    rd_status(st);
    check8(st, 8'h00);
    frame(4, 32'h0306_0000);
    check8(rx, 8'hA1);
    $display("test array done");
  endtask : t_array
  // levels, protect pin refusal, abort, launched cycle, pin ignored
  task automatic t_protect;
    logic [7:0] st;
    frame(1, 32'h0000_0006);
    frame(2, 32'h0000_0184);
    wait_ready();
    rd_status(st);
    check8(st, 8'h84);
    frame(1, 32'h0000_0006);
    frame(4, 32'h0206_005E);
    wait_ready();
    frame(1, 32'h0000_0006);
    frame(4, 32'h0205_FF11);
    wait_ready();
    frame(4, 32'h0306_0000);
    check8(rx, 8'hA1);
    frame(4, 32'h0305_FF00);
    check8(rx, 8'h11);
    frame(1, 32'h0000_0006);
    set_wp(1'b0);
    frame(2, 32'h0000_0100);
    rd_status(st);
    check8(st, 8'h86);
    set_wp(1'b1);
    i_master.open_frame();
    i_master.xfer(8'h01, rx);
    i_master.xfer(8'h00, rx);
    set_wp(1'b0);
    i_master.close_frame();
    set_wp(1'b1);
    rd_status(st);
    check8(st, 8'h86);
    frame(2, 32'h0000_0180);
    set_wp(1'b0);
    wait_ready();
    rd_status(st);
    check8(st, 8'h80);
    set_wp(1'b1);
    frame(1, 32'h0000_0006);
    frame(2, 32'h0000_0100);
    wait_ready();
    set_wp(1'b0);
    frame(1, 32'h0000_0006);
    frame(2, 32'h0000_018C);
    wait_ready();
    rd_status(st);
    check8(st, 8'h8C);
    $display("test protect done");
  endtask : t_protect
  // bad opcode swallows the rest of the frame, next frame works
  task automatic t_bad_opcode;
    logic [7:0] st;
    i_master.open_frame();
    i_master.xfer(8'h0F, rx);
    i_master.xfer(8'h06, rx);
    check1(so_oe, 1'b0);
    i_master.close_frame();
    rd_status(st);
    check8(st, 8'h8C);
    $display("test bad opcode done");
  endtask : t_bad_opcode
  // pause after the opcode; three sck pulses would rotate the byte
  task automatic t_hold;
    i_master.open_frame();
    i_master.xfer(8'h05, rx);
    i_master.pause_on(3);
    check1(so_oe, 1'b0);
    i_master.pause_off();
    i_master.xfer(8'h00, rx);
    i_master.close_frame();
    check8(rx, 8'h8C);
    $display("test hold done");
  endtask : t_hold
  // main sequence
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    t_reset();
    t_latch();
    t_array();
    t_protect();
    t_bad_opcode();
    t_hold();
    stop_test();
  end
endmodule : tb_spe_front_end
